// ===== design/dtc_timer.sv
// Dual 8/16-bit timer/counter with external pin interrupt flags and enables.
`timescale 1ns/100ps
`default_nettype none
`include "dtc_map.svh"

// Summary of operation
// - Timer A counts only while its run bit is one, else holds; the mode 11 high byte follows B run.
// - Timer B counts only while its run bit is one, else holds.
// - Pin falling edge sets the external flag; vectoring clears it.
// - Trigger select zero: low level requests; one: falling edge requests.
// - Gating one adds the external pin high as a count condition.
// - Timer mode advances the count once every two clocks.
// - Counter mode advances the count on each source falling edge.
// - Input select picks the count pin or slow clock divided by four.
// - Mode 00 is an 8-bit high byte behind a 5-bit low prescaler.
// - Mode 01 joins both bytes into one 16-bit up-counter.
// - Mode 10 reloads the low byte from the high byte on overflow.
// - Timer B in mode 11 stops counting.
// - Timer A mode 11 splits; high byte uses B run and B flag.
// - Overflow sets the timer flag; vectoring to its routine clears it.
// - Count bytes are readable, writable and reset to zero.
// - Global enable zero blocks all requests; one defers to own enables.
// - Timer enable one lets its overflow flag raise a request.
// - External enable one allows request and wake-up through that pin.
module dtc_timer
	import dtc_pkg::*;
(
	input  wire logic       mclk,
	input  wire logic       reset,
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	input  wire logic       ext_pin_a,
	input  wire logic       ext_pin_b,
	input  wire logic       count_pin_a,
	input  wire logic       count_pin_b,
	input  wire logic       slow_clk_div4,
	input  wire logic       count_input_sel_a,
	input  wire logic       count_input_sel_b,
	input  wire logic       vec_ack_tmr_a,
	input  wire logic       vec_ack_tmr_b,
	input  wire logic       vec_ack_ext_a,
	input  wire logic       vec_ack_ext_b,
	output logic            irq_tmr_a,
	output logic            irq_tmr_b,
	output logic            irq_ext_a,
	output logic            irq_ext_b,
	output logic            wake_ext_a,
	output logic            wake_ext_b
);

	// ****************************************
	// Count step
	// ****************************************
	// Returns {overflow, high byte, low byte} after one count event.
	function automatic logic [16:0] dtc_step(
		input logic [1:0] mode,
		input logic       tick,
		input logic [7:0] lo,
		input logic [7:0] hi
	);
		logic [15:0] w;
		logic        pwrap;
		w = {hi, lo};
		pwrap = (lo[4:0] == 5'h1f);
		dtc_step = {1'b0, w};
		if (tick) begin
			case (mode)
				`DTC_MODE_PRESCALE: begin
					dtc_step = {pwrap && (hi == 8'hff), pwrap ? hi + 8'h01 : hi,
						lo[7:5], lo[4:0] + 5'h01};
				end
				`DTC_MODE_WIDE: begin
					dtc_step = {w == 16'hffff, w + 16'h0001};
				end
				`DTC_MODE_RELOAD: begin
					dtc_step = {lo == 8'hff, hi, (lo == 8'hff) ? hi : lo + 8'h01};
				end
				default: begin
					dtc_step = {lo == 8'hff, hi, lo + 8'h01};
				end
			endcase
		end
	endfunction

	// ****************************************
	// State and count conditions
	// ****************************************
	dtc_state_t  r;
	dtc_state_t  s;
	logic        src_a;
	logic        src_b;
	logic        en_a;
	logic        en_b;
	logic        tick_a;
	logic        tick_b;
	logic        tick_h;
	logic        split_a;
	logic        ovf_h;
	logic [1:0]  mode_a;
	logic [1:0]  mode_b;
	logic [16:0] step_a;
	logic [16:0] step_b;
	logic [1:0]  ext_pins;
	logic [1:0]  ext_acks;
	logic        wr_a;
	logic        wr_b;

	assign mode_a   = r.tmode_r[`DTC_TM_MODE_A];
	assign mode_b   = r.tmode_r[`DTC_TM_MODE_B];
	assign ext_pins = {ext_pin_b, ext_pin_a};
	assign ext_acks = {vec_ack_ext_b, vec_ack_ext_a};
	assign src_a    = count_input_sel_a ? slow_clk_div4 : count_pin_a;
	assign src_b    = count_input_sel_b ? slow_clk_div4 : count_pin_b;
	assign en_a     = r.tctrl_r[`DTC_TC_RUN_A]
		& (~r.tmode_r[`DTC_TM_GATE_A] | ext_pin_a);
	assign en_b     = r.tctrl_r[`DTC_TC_RUN_B]
		& (~r.tmode_r[`DTC_TM_GATE_B] | ext_pin_b)
		& (mode_b != `DTC_MODE_SPLIT);
	// The divider phase gives one event every two clocks in timer mode.
	assign tick_a   = en_a & (r.tmode_r[`DTC_TM_CSEL_A] ? (r.pin_prev_r[2] & ~src_a)
		: r.div_r);
	assign tick_b   = en_b & (r.tmode_r[`DTC_TM_CSEL_B] ? (r.pin_prev_r[3] & ~src_b)
		: r.div_r);
	assign split_a  = (mode_a == `DTC_MODE_SPLIT);
	assign tick_h   = split_a & r.tctrl_r[`DTC_TC_RUN_B] & r.div_r;
	assign ovf_h    = tick_h & (r.th_a_r == 8'hff);
	assign step_a   = dtc_step(mode_a, tick_a, r.tl_a_r, r.th_a_r);
	assign step_b   = dtc_step(mode_b, tick_b, r.tl_b_r, r.th_b_r);
	assign wr_a     = sfr_wr && (sfr_addr == `DTC_ADDR_TL_A || sfr_addr == `DTC_ADDR_TH_A);
	assign wr_b     = sfr_wr && (sfr_addr == `DTC_ADDR_TL_B || sfr_addr == `DTC_ADDR_TH_B);

	// ****************************************
	// Next state
	// ****************************************
	// Software writes override counting; hardware flag sets win over any clear.
	always_comb begin
		s = r;
		s.div_r = ~r.div_r;
		s.pin_prev_r = {src_b, src_a, ext_pin_b, ext_pin_a};
		s.tl_a_r = step_a[7:0];
		s.th_a_r = split_a ? r.th_a_r + {7'h00, tick_h} : step_a[15:8];
		s.tl_b_r = step_b[7:0];
		s.th_b_r = step_b[15:8];
		if (vec_ack_tmr_a) begin
			s.tctrl_r[`DTC_TC_OVF_A] = 1'b0;
		end
		if (vec_ack_tmr_b) begin
			s.tctrl_r[`DTC_TC_OVF_B] = 1'b0;
		end
		for (int i = 0; i < 2; i++) begin
			if (ext_acks[i]) begin
				s.tctrl_r[`DTC_TC_EXTF_A + `DTC_TC_EXT_STRIDE * i] = 1'b0;
			end
		end
		if (sfr_wr) begin
			case (sfr_addr)
				`DTC_ADDR_TCTRL: s.tctrl_r = sfr_wdata;
				`DTC_ADDR_TMODE: s.tmode_r = sfr_wdata;
				`DTC_ADDR_TL_A:  s.tl_a_r = sfr_wdata;
				`DTC_ADDR_TH_A:  s.th_a_r = sfr_wdata;
				`DTC_ADDR_TL_B:  s.tl_b_r = sfr_wdata;
				`DTC_ADDR_TH_B:  s.th_b_r = sfr_wdata;
				`DTC_ADDR_IRQEN: s.irqen_r = sfr_wdata & `DTC_IE_MASK;
				default: begin
				end
			endcase
		end
		if (step_a[16]) begin
			s.tctrl_r[`DTC_TC_OVF_A] = 1'b1;
		end
		// While A is split its high byte owns the B flag, so B overflows are lost.
		if (split_a ? ovf_h : step_b[16]) begin
			s.tctrl_r[`DTC_TC_OVF_B] = 1'b1;
		end
		for (int i = 0; i < 2; i++) begin
			if (r.tctrl_r[`DTC_TC_TRIG_A + `DTC_TC_EXT_STRIDE * i]
				? (r.pin_prev_r[i] & ~ext_pins[i]) : ~ext_pins[i]) begin
				s.tctrl_r[`DTC_TC_EXTF_A + `DTC_TC_EXT_STRIDE * i] = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign irq_tmr_a  = r.irqen_r[`DTC_IE_GLOBAL]
		& r.irqen_r[`DTC_IE_TMR_A] & r.tctrl_r[`DTC_TC_OVF_A];
	assign irq_tmr_b  = r.irqen_r[`DTC_IE_GLOBAL]
		& r.irqen_r[`DTC_IE_TMR_B] & r.tctrl_r[`DTC_TC_OVF_B];
	assign irq_ext_a  = r.irqen_r[`DTC_IE_GLOBAL]
		& r.irqen_r[`DTC_IE_EXT_A] & r.tctrl_r[`DTC_TC_EXTF_A];
	assign irq_ext_b  = r.irqen_r[`DTC_IE_GLOBAL]
		& r.irqen_r[`DTC_IE_EXT_B] & r.tctrl_r[`DTC_TC_EXTF_A + `DTC_TC_EXT_STRIDE];
	// Wake-up ignores the global enable so a halted core can still be woken.
	assign wake_ext_a = r.irqen_r[`DTC_IE_EXT_A] & r.tctrl_r[`DTC_TC_EXTF_A];
	assign wake_ext_b = r.irqen_r[`DTC_IE_EXT_B]
		& r.tctrl_r[`DTC_TC_EXTF_A + `DTC_TC_EXT_STRIDE];

	always_comb begin
		case (sfr_addr)
			`DTC_ADDR_TCTRL: sfr_rdata = r.tctrl_r;
			`DTC_ADDR_TMODE: sfr_rdata = r.tmode_r;
			`DTC_ADDR_TL_A:  sfr_rdata = r.tl_a_r;
			`DTC_ADDR_TH_A:  sfr_rdata = r.th_a_r;
			`DTC_ADDR_TL_B:  sfr_rdata = r.tl_b_r;
			`DTC_ADDR_TH_B:  sfr_rdata = r.th_b_r;
			`DTC_ADDR_IRQEN: sfr_rdata = r.irqen_r;
			default:         sfr_rdata = 8'h00;
		endcase
	end

	// ****************************************
	// Checks
	// ****************************************
	a_hold_stop_a: assert property (@(posedge mclk) disable iff (reset)
		(!r.tctrl_r[`DTC_TC_RUN_A] && !wr_a && !split_a)
		|=> (r.tl_a_r == $past(r.tl_a_r)) && (r.th_a_r == $past(r.th_a_r)))
		else $error("Timer A moved while stopped.");

	a_hold_stop_b: assert property (@(posedge mclk) disable iff (reset)
		(!r.tctrl_r[`DTC_TC_RUN_B] && !wr_b)
		|=> (r.tl_b_r == $past(r.tl_b_r)) && (r.th_b_r == $past(r.th_b_r)))
		else $error("Timer B moved while stopped.");

	a_ext_edge_set: assert property (@(posedge mclk) disable iff (reset)
		(r.tctrl_r[`DTC_TC_TRIG_A] && r.pin_prev_r[0] && !ext_pin_a)
		|=> r.tctrl_r[`DTC_TC_EXTF_A])
		else $error("Falling edge did not set external flag A.");

	a_ext_level_set: assert property (@(posedge mclk) disable iff (reset)
		(!r.tctrl_r[`DTC_TC_TRIG_A] && !ext_pin_a)
		|=> r.tctrl_r[`DTC_TC_EXTF_A] && irq_ext_a == (r.irqen_r[`DTC_IE_GLOBAL]
		&& r.irqen_r[`DTC_IE_EXT_A]))
		else $error("Low level did not raise external flag A.");

	a_gate_blocks: assert property (@(posedge mclk) disable iff (reset)
		(r.tmode_r[`DTC_TM_GATE_A] && !ext_pin_a && !wr_a && !split_a)
		|=> r.tl_a_r == $past(r.tl_a_r))
		else $error("Gated timer A counted with pin low.");

	a_timer_rate: assert property (@(posedge mclk) disable iff (reset)
		(en_a && !r.tmode_r[`DTC_TM_CSEL_A] && mode_a == `DTC_MODE_WIDE && !wr_a)
		|=> r.tl_a_r == $past(r.tl_a_r) + {7'h00, $past(r.div_r)})
		else $error("Timer A rate is not one per two clocks.");

	a_count_edge: assert property (@(posedge mclk) disable iff (reset)
		(en_a && r.tmode_r[`DTC_TM_CSEL_A] && mode_a == `DTC_MODE_WIDE && !wr_a
		&& r.pin_prev_r[2] && !src_a)
		|=> r.tl_a_r == $past(r.tl_a_r) + 8'h01)
		else $error("Counter A missed a falling edge.");

	a_reload_ovf: assert property (@(posedge mclk) disable iff (reset)
		(tick_a && mode_a == `DTC_MODE_RELOAD && r.tl_a_r == 8'hff && !wr_a)
		|=> r.tl_a_r == $past(r.th_a_r) && r.tctrl_r[`DTC_TC_OVF_A])
		else $error("Reload mode did not reload and flag.");

	a_b_stopped: assert property (@(posedge mclk) disable iff (reset)
		(mode_b == `DTC_MODE_SPLIT && !wr_b) |=> r.tl_b_r == $past(r.tl_b_r))
		else $error("Timer B counted in mode 11.");

	a_global_off: assert property (@(posedge mclk) disable iff (reset)
		!r.irqen_r[`DTC_IE_GLOBAL] |-> !(irq_tmr_a || irq_tmr_b || irq_ext_a || irq_ext_b))
		else $error("Request raised with global enable off.");

	a_ovf_vec_clr: assert property (@(posedge mclk) disable iff (reset)
		(vec_ack_tmr_a && !step_a[16] && !(sfr_wr && sfr_addr == `DTC_ADDR_TCTRL))
		|=> !r.tctrl_r[`DTC_TC_OVF_A])
		else $error("Vector acknowledge did not clear flag A.");

	a_prescale_wrap: assert property (@(posedge mclk) disable iff (reset)
		(tick_a && mode_a == `DTC_MODE_PRESCALE && r.tl_a_r[4:0] == 5'h1f && !wr_a)
		|=> r.th_a_r == $past(r.th_a_r) + 8'h01
		&& r.tl_a_r == {$past(r.tl_a_r[7:5]), 5'h00})
		else $error("Prescaler wrap did not advance high byte A.");

	a_wide_carry_b: assert property (@(posedge mclk) disable iff (reset)
		(tick_b && mode_b == `DTC_MODE_WIDE && r.tl_b_r == 8'hff && !wr_b)
		|=> r.tl_b_r == 8'h00 && r.th_b_r == $past(r.th_b_r) + 8'h01)
		else $error("Timer B low byte did not carry into high byte.");

	a_split_high: assert property (@(posedge mclk) disable iff (reset)
		(tick_h && r.th_a_r == 8'hff && !wr_a)
		|=> r.th_a_r == 8'h00 && r.tctrl_r[`DTC_TC_OVF_B])
		else $error("Split high byte did not wrap into flag B.");

	a_ext_edge_b: assert property (@(posedge mclk) disable iff (reset)
		(r.tctrl_r[`DTC_TC_TRIG_A + `DTC_TC_EXT_STRIDE] && r.pin_prev_r[1] && !ext_pin_b)
		|=> r.tctrl_r[`DTC_TC_EXTF_A + `DTC_TC_EXT_STRIDE])
		else $error("Falling edge did not set external flag B.");

	a_ext_ack_clr: assert property (@(posedge mclk) disable iff (reset)
		(vec_ack_ext_a && r.tctrl_r[`DTC_TC_TRIG_A] && !(r.pin_prev_r[0] && !ext_pin_a)
		&& !(sfr_wr && sfr_addr == `DTC_ADDR_TCTRL))
		|=> !r.tctrl_r[`DTC_TC_EXTF_A])
		else $error("Vector acknowledge did not clear external flag A.");

endmodule
`default_nettype wire

// ===== design/dtc_map.svh
// Register offsets, field positions, reset values and timing counts of the dual timer.
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define DTC_ADDR_TCTRL      8'h88
`define DTC_ADDR_TMODE      8'h89
`define DTC_ADDR_TL_A       8'h8a
`define DTC_ADDR_TL_B       8'h8b
`define DTC_ADDR_TH_A       8'h8c
`define DTC_ADDR_TH_B       8'h8d
`define DTC_ADDR_IRQEN      8'ha8

// ****************************************
// Timer control register fields
// ****************************************
`define DTC_TC_OVF_B        7
`define DTC_TC_RUN_B        6
`define DTC_TC_OVF_A        5
`define DTC_TC_RUN_A        4
`define DTC_TC_EXTF_A       1
`define DTC_TC_TRIG_A       0
`define DTC_TC_EXT_STRIDE   2

// ****************************************
// Timer mode register fields
// ****************************************
`define DTC_TM_GATE_B       7
`define DTC_TM_CSEL_B       6
`define DTC_TM_MODE_B       5:4
`define DTC_TM_GATE_A       3
`define DTC_TM_CSEL_A       2
`define DTC_TM_MODE_A       1:0

// ****************************************
// Interrupt enable register fields
// ****************************************
`define DTC_IE_GLOBAL       7
`define DTC_IE_TMR_B        3
`define DTC_IE_EXT_B        2
`define DTC_IE_TMR_A        1
`define DTC_IE_EXT_A        0
`define DTC_IE_MASK         8'h8f

// ****************************************
// Mode codes, reset values, timing
// ****************************************
`define DTC_MODE_PRESCALE   2'h0
`define DTC_MODE_WIDE       2'h1
`define DTC_MODE_RELOAD     2'h2
`define DTC_MODE_SPLIT      2'h3
`define DTC_RST_BYTE        8'h00
`define DTC_RST_BIT         1'b0
`define DTC_RST_PINS        4'h0
`define DTC_TIMER_DIV       2

`endif

// ===== design/dtc_pkg.sv
// Types shared by the dual timer design.
package dtc_pkg;

	typedef struct packed {
		logic [7:0] tctrl_r;
		logic [7:0] tmode_r;
		logic [7:0] tl_a_r;
		logic [7:0] th_a_r;
		logic [7:0] tl_b_r;
		logic [7:0] th_b_r;
		logic [7:0] irqen_r;
		logic       div_r;
		logic [3:0] pin_prev_r;
	} dtc_state_t;

endpackage

// ===== sim/dtc_timer_tb.sv
// Self-checking bench for the dual timer: registers, counting modes, flags and requests.
`timescale 1ns/100ps
`default_nettype none
module dtc_timer_tb;
	logic        mclk, reset, sfr_wr, count_pin_a, slow_clk_div4, count_input_sel_a;
	logic        count_pin_b, count_input_sel_b;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata;
	logic [1:0]  ext_v;
	logic [3:0]  ack_v;
	wire logic [5:0] irq_v;
	logic [31:0] lfsr_r;
	int          miscompares, cmp_count;
	logic [7:0]  regs [7] = '{8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'ha8, 8'h88};

	dtc_timer dtc_timer_i (.mclk, .reset, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata,
		.ext_pin_a(ext_v[0]), .ext_pin_b(ext_v[1]), .count_pin_a, .count_pin_b,
		.slow_clk_div4, .count_input_sel_a, .count_input_sel_b,
		.vec_ack_tmr_a(ack_v[0]), .vec_ack_tmr_b(ack_v[1]), .vec_ack_ext_a(ack_v[2]),
		.vec_ack_ext_b(ack_v[3]), .irq_tmr_a(irq_v[0]), .irq_tmr_b(irq_v[1]),
		.irq_ext_a(irq_v[2]), .irq_ext_b(irq_v[3]), .wake_ext_a(irq_v[4]), .wake_ext_b(irq_v[5]));

	// ****************************************
	// Bench helpers and reference model
	// ****************************************
	function automatic logic [31:0] rnd();
		lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
		return lfsr_r;
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Every write leaves one idle cycle so the strobe is never raised twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge mclk);
		sfr_wr = 1'b0;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		sfr_addr = a;
		#1 check(sfr_rdata, exp);
	endtask
	task automatic ack(input int w);
		@(negedge mclk);
		ack_v[w] = 1'b1;
		@(negedge mclk);
		ack_v = 4'h0;
	endtask
	// One count event of the model; mode 0 keeps low bits 7:5 untouched.
	function automatic void step(input int m, inout int lo, inout int hi, inout int ovf);
		lo = (m == 0) ? (lo & 8'he0) | ((lo + 1) & 8'h1f) : (lo + 1) & 8'hff;
		if ((m == 0 && (lo & 8'h1f) == 0) || (m == 1 && lo == 0)) begin
			hi = (hi + 1) & 8'hff;
			ovf = ovf | (hi == 0);
		end
		if (m >= 2 && lo == 0) begin
			ovf = 1;
			if (m == 2) lo = hi;
		end
	endfunction
	// An even number of idle cycles holds exactly half as many divider phases, whatever
	// the phase was when the run bit landed.
	task automatic run_t(input int t, input int m, input int k, input int g);
		int lo, hi, ovf;
		lo = int'(rnd() % 256);
		hi = (m < 2) ? 255 : int'(rnd() % 256);
		ovf = 0;
		wr(8'h8a + 8'(t), 8'(lo));
		wr(8'h8c + 8'(t), 8'(hi));
		wr(8'h89, 8'((m + 8 * g) << (4 * t)));
		idle(4);
		rd(8'h8a + 8'(t), 8'(lo));
		wr(8'h88, 8'(8'h10 << (2 * t)));
		idle(2 * k);
		if (!(t == 1 && m == 3)) repeat (k) step(m, lo, hi, ovf);
		rd(8'h8a + 8'(t), 8'(lo));
		rd(8'h8c + 8'(t), 8'(hi));
		rd(8'h88, 8'((ovf << (5 + 2 * t)) | (8'h10 << (2 * t))));
		if (g != 0) begin
			ext_v[t] = 1'b0;
			idle(4);
			rd(8'h8a + 8'(t), 8'(lo));
			ext_v[t] = 1'b1;
		end
		// A flag raised on the stopping edge survives that write, so clear once more.
		wr(8'h88, 8'h00);
		wr(8'h88, 8'h00);
	endtask

	// ****************************************
	// Stimulus
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	initial begin
		repeat (60000) @(posedge mclk);
		miscompares++;
		complete_run();
	end
	initial begin
		logic [7:0] d;
		int n;
		{reset, sfr_wr, sfr_addr, sfr_wdata, ack_v} = {1'b1, 1'b0, 8'h00, 8'h00, 4'h0};
		{ext_v, count_pin_a, slow_clk_div4, count_input_sel_a} = {2'h3, 1'b1, 1'b1, 1'b0};
		{count_pin_b, count_input_sel_b} = {1'b1, 1'b0};
		lfsr_r = 32'h72c0_80f5;
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		foreach (regs[i]) rd(regs[i], 8'h00);
		foreach (regs[i]) begin
			d = 8'(rnd());
			wr(regs[i], d);
			rd(regs[i], (regs[i] == 8'ha8) ? d & 8'h8f : d);
		end
		wr(8'h88, 8'h00);
		wr(8'h88, 8'h00);
		wr(8'ha8, 8'h00);
		wr(8'h8e, 8'h5a);
		rd(8'h8e, 8'h00);
		for (int i = 0; i < 8; i++) run_t(i % 2, i / 2, 260 + int'(rnd() % 40), (i / 2) % 2);
		wr(8'h89, 8'h03);
		wr(8'h8c, 8'hfe);
		wr(8'h88, 8'h40);
		idle(4);
		rd(8'h8c, 8'h00);
		rd(8'h88, 8'hc0);
		wr(8'h88, 8'h00);
		// The unused source toggles every cycle so a wrong selection cannot go unseen.
		for (int j = 0; j < 4; j++) begin
			n = 3 + int'(rnd() % 8);
			{count_input_sel_b, count_input_sel_a} = {2{j[0]}};
			wr(8'h8a + 8'(j / 2), 8'h00);
			wr(8'h8c + 8'(j / 2), 8'h00);
			wr(8'h89, 8'h55);
			wr(8'h88, 8'(8'h10 << (2 * (j / 2))));
			for (int i = 0; i < 4 * n; i++) begin
				@(negedge mclk);
				{count_pin_b, count_pin_a} = {2{j[0] ? i[0] : (i % 4 < 2)}};
				slow_clk_div4 = j[0] ? (i % 4 < 2) : i[0];
			end
			idle(3);
			rd(8'h8a + 8'(j / 2), 8'(n));
			wr(8'h88, 8'h00);
		end
		for (int t = 0; t < 2; t++) begin
			wr(8'ha8, 8'h0f);
			wr(8'h88, 8'(8'h01 << (2 * t)));
			ext_v[t] = 1'b0;
			idle(2);
			rd(8'h88, 8'(8'h03 << (2 * t)));
			check(irq_v[4 + t], 1'b1);
			check(irq_v[2 + t], 1'b0);
			wr(8'ha8, 8'h8f);
			check(irq_v[2 + t], 1'b1);
			ack(2 + t);
			rd(8'h88, 8'(8'h01 << (2 * t)));
			wr(8'h88, 8'h00);
			// Level sensing starts only on the edge after the select bit has landed.
			idle(1);
			rd(8'h88, 8'(8'h02 << (2 * t)));
			ack(2 + t);
			rd(8'h88, 8'(8'h02 << (2 * t)));
			ext_v[t] = 1'b1;
			ack(2 + t);
			rd(8'h88, 8'h00);
			wr(8'h88, 8'(8'h20 << (2 * t)));
			check(irq_v[t], 1'b1);
			wr(8'ha8, 8'h0f);
			check(irq_v[t], 1'b0);
			ack(t);
			rd(8'h88, 8'h00);
		end
		@(negedge mclk);
		reset = 1'b1;
		idle(2);
		reset = 1'b0;
		foreach (regs[i]) rd(regs[i], 8'h00);
		complete_run();
	end
endmodule
`default_nettype wire
